// File: hdl/pwt_pkg.sv
// Constants shared by the target write path
package pwt_pkg;
	localparam int           NUM_BAR      = 6;       // Base address windows
	localparam int           TSR_W        = 12;      // Width of the target status vector
	localparam int           TSR_BIT_W64  = 7;       // Pending transfer is 64 bits
	localparam int           TSR_BIT_BUSY = 8;       // PCI side busy
	localparam int           TSR_BIT_XOK  = 10;      // PCI side transfer done
	localparam logic [3:0]   CMD_MEM_WR   = 4'h7;    // Memory write bus command
	localparam logic [11:0]  TSR_RST      = 12'h000; // Status vector after reset
	localparam int           FIFO_DEPTH   = 16;      // Write data buffer depth
	localparam int           FIFO_WIDTH   = 72;      // 64 data bits and 8 enables

	// Target sequencer states
	typedef enum logic [2:0] {
		PWT_IDLE   = 3'h0,
		PWT_DECODE = 3'h1,
		PWT_CLAIM  = 3'h2,
		PWT_WAIT   = 3'h3,
		PWT_DATA   = 3'h4,
		PWT_END    = 3'h5,
		PWT_TURN   = 3'h6
	} pwt_state_t;
endpackage

// File: hdl/pwt_target.sv
// Target write path: PCI address decode, claim, one data phase, local hand-off
`timescale 1ns/1ps

// Flip-flop FIFO with valid/ready on both sides
module pwt_fifo #(
	parameter int W = 72,
	parameter int D = 16
) (
	input  wire logic         clk,       // System clock
	input  wire logic         rst,       // Async reset
	input  wire logic         in_valid,  // Write request
	output logic              in_ready,  // Room for a word
	input  wire logic [W-1:0] in_data,   // Word written
	output logic              out_valid, // Word available
	input  wire logic         out_ready, // Consumer takes word
	output logic      [W-1:0] out_data   // Head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	wire          push = in_valid && in_ready;
	wire          pop  = out_valid && out_ready;

	// Full when pointers differ only in the wrap bit
	assign in_ready  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid = (wp_r != rp_r);
	assign out_data  = mem_r[rp_r[AW-1:0]];

	// Storage is not reset; only pointers carry state
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r[AW-1:0]] <= in_data;
		end
	end

	// Pointer update
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_r + (AW+1)'(push);
			rp_r <= rp_r + (AW+1)'(pop);
		end
	end
endmodule // pwt_fifo

// What this block does
// R1: Master drives frame, req64, address, command
// R2: Asserted req64 in address phase means 64-bit
// R3: On hit, enable target drivers next cycle
// R4: Assert devsel and ack64 to claim
// R5: Latch address/command, decode against BARs
// R6: Master drops frame, asserts irdy: single phase
// R7: On hit assert local frame and BAR status bit
// R8: Present command and address with local frame
// R9: Status bit 7 marks 64-bit transfer
// R10: Status bit 8 marks PCI side busy
// R11: Hold trdy until local side ready
// R12: Local ready means data accepted next cycle
// R13: Assert trdy when local side ready
// R14: 32-bit build drops all 64-bit extension signals
// R15: 64-bit build accepts 32-bit writes as mismatched
// R16: Register data, enables; assert data valid
// R17: Strobe on ready-then-valid; set status bit 10
// R18: Drive controls high one cycle, then release
// R19: Drop local frame once pipeline is empty
// R20: No hit: no drivers, no local signals
module pwt_target import pwt_pkg::*; #(
	parameter bit WIDE = 1'b1  // 64-bit build when set
) (
	input  wire logic                  clk,               // PCI clock, 200 MHz
	input  wire logic                  rst,               // Async reset, active high
	input  wire logic                  framen,            // Bus frame
	input  wire logic                  req64n,            // 64-bit request
	input  wire logic                  irdyn,             // Initiator ready
	input  wire logic [63:0]           ad_i,              // Address/data in
	input  wire logic [7:0]            cben_i,            // Command/byte enables in
	input  wire logic [NUM_BAR*32-1:0] bar_base,          // BAR base addresses
	input  wire logic [NUM_BAR*32-1:0] bar_mask,          // Address bits compared
	input  wire logic [NUM_BAR-1:0]    bar_en,            // Memory BAR enabled
	output logic                       devseln_o,         // Device select out
	output logic                       devseln_oe,        // Devsel driven
	output logic                       trdyn_o,           // Target ready out
	output logic                       trdyn_oe,          // Trdy driven
	output logic                       stopn_o,           // Stop out
	output logic                       stopn_oe,          // Stop driven
	output logic                       ack64n_o,          // 64-bit ack out
	output logic                       ack64n_oe,         // Ack64 driven
	input  wire logic                  local_ready_n,     // Local side ready
	output logic                       local_txn_frame_n, // Local transaction frame
	output logic [TSR_W-1:0]           target_status_vector, // Target status
	output logic [3:0]                 local_cmd,         // Latched command
	output logic [31:0]                local_adr,         // Latched address
	output logic [63:0]                local_wdata,       // Write data
	output logic [7:0]                 local_be_n,        // Byte enables, low active
	output logic                       local_data_valid_n, // Data valid
	output logic                       local_xfer_strobe_n // Local transfer
);
	pwt_state_t          state_r, state_nxt;
	logic                frame_q_r;
	logic [31:0]         adr_r;
	logic [3:0]          cmd_r;
	logic                w64_r;
	logic                rdy_q_r;
	logic [NUM_BAR-1:0]  bar_hit;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [FIFO_WIDTH-1:0] fifo_out;
	logic [FIFO_WIDTH-1:0] fifo_in;

	// Address phase is the falling edge of frame while idle
	wire addr_phase = (state_r == PWT_IDLE) && !framen && frame_q_r;               // R1
	wire hit        = |bar_hit;
	wire data_done  = (state_r == PWT_DATA) && !irdyn;                             // R6
	wire go_data    = (state_r == PWT_WAIT) && !local_ready_n && fifo_in_ready;    // R11

	// Per-window compare of the latched address
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BAR; gi++) begin : g_bar
			assign bar_hit[gi] = bar_en[gi] && (cmd_r == CMD_MEM_WR) &&
				(((adr_r ^ bar_base[gi*32 +: 32]) & bar_mask[gi*32 +: 32]) == 32'h0000_0000); // R5
		end
	endgenerate

	// Narrow writes land in the lane picked by address bit 2; idle lane disabled
	wire        narrow = !w64_r;                                                   // R15
	wire        hi_ln  = narrow && adr_r[2];
	wire [63:0] wd     = narrow ? {ad_i[31:0], ad_i[31:0]} : ad_i;
	wire [7:0]  be     = !narrow ? cben_i : (hi_ln ? {cben_i[3:0], 4'hF} : {4'hF, cben_i[3:0]});
	assign fifo_in = {be, wd};                                                     // R16

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			PWT_IDLE:   if (addr_phase) state_nxt = PWT_DECODE;
			PWT_DECODE: state_nxt = hit ? PWT_CLAIM : PWT_IDLE;                      // R20
			PWT_CLAIM:  state_nxt = PWT_WAIT;
			PWT_WAIT:   if (go_data) state_nxt = PWT_DATA;                           // R11
			PWT_DATA:   if (data_done) state_nxt = PWT_END;
			PWT_END:    state_nxt = PWT_TURN;
			PWT_TURN:   state_nxt = PWT_IDLE;
			default:    state_nxt = PWT_IDLE;
		endcase
	end

	// State and address-phase capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r   <= PWT_IDLE;
			frame_q_r <= 1'b1;
			adr_r     <= 32'h0000_0000;
			cmd_r     <= 4'h0;
			w64_r     <= 1'b0;
			rdy_q_r   <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			frame_q_r <= framen;
			rdy_q_r   <= !local_ready_n;
			if (addr_phase) begin
				adr_r <= ad_i[31:0];                                                 // R5
				cmd_r <= cben_i[3:0];
				w64_r <= WIDE && !req64n;                                            // R2 R14
			end
		end
	end

	// PCI control pins; 32-bit build never touches ack64
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			devseln_oe <= 1'b0;
			devseln_o  <= 1'b1;
			trdyn_o    <= 1'b1;
			ack64n_o   <= 1'b1;
			ack64n_oe  <= 1'b0;
		end else begin
			if (state_r == PWT_DECODE && hit) begin
				devseln_oe <= 1'b1;                                                  // R3
				ack64n_oe  <= w64_r;                                                 // R14
			end else if (state_r == PWT_END) begin
				devseln_oe <= 1'b0;                                                  // R18
				ack64n_oe  <= 1'b0;
			end
			devseln_o <= !(state_r == PWT_CLAIM || state_r == PWT_WAIT ||
				(state_r == PWT_DATA && !data_done));                                // R4 R18
			ack64n_o  <= !(w64_r && (state_r == PWT_CLAIM || state_r == PWT_WAIT ||
				(state_r == PWT_DATA && !data_done)));                               // R4
			trdyn_o   <= !(go_data || (state_r == PWT_DATA && !data_done));          // R13
		end
	end
	// No retry or disconnect in this path, so stop is only driven high
	assign trdyn_oe = devseln_oe;                                                  // R3
	assign stopn_oe = devseln_oe;
	assign stopn_o  = 1'b1;

	// Local frame, status and latched address/command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			local_txn_frame_n    <= 1'b1;
			target_status_vector <= TSR_RST;
			local_cmd            <= 4'h0;
			local_adr            <= 32'h0000_0000;
		end else begin
			if (state_r == PWT_DECODE && hit) begin
				local_txn_frame_n <= 1'b0;                                           // R7
				local_cmd         <= cmd_r;                                          // R8
				local_adr         <= adr_r;
				target_status_vector[NUM_BAR-1:0]   <= bar_hit;                      // R7
				target_status_vector[TSR_BIT_W64]   <= w64_r;                        // R9
				target_status_vector[TSR_BIT_BUSY]  <= 1'b1;                         // R10
			end else if (state_r == PWT_END) begin
				target_status_vector <= TSR_RST;                                     // R18
			end else if (data_done) begin
				target_status_vector[TSR_BIT_XOK] <= 1'b1;                           // R17
			end
			// Held until every buffered word has gone to the local side
			if ((state_r == PWT_TURN || state_r == PWT_IDLE) && !fifo_out_valid &&
				!local_txn_frame_n) begin
				local_txn_frame_n <= 1'b1;                                           // R19
			end
		end
	end

	// Buffer between PCI data phase and local side; full stalls trdy
	pwt_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (data_done),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (rdy_q_r),
		.out_data  (fifo_out)
	);

	// Local data side
	assign local_wdata         = fifo_out[63:0];                                   // R16
	assign local_be_n          = fifo_out[71:64];
	assign local_data_valid_n  = !fifo_out_valid;                                  // R16
	assign local_xfer_strobe_n = !(fifo_out_valid && rdy_q_r);                     // R12 R17

	AST_HIT_OE: assert property (@(posedge clk) disable iff (rst) // R3
		(state_r == PWT_DECODE && hit) |=> (devseln_oe && trdyn_oe && stopn_oe && devseln_o))
		else $error("drivers not enabled after hit");
	AST_NOHIT: assert property (@(posedge clk) disable iff (rst) // R20
		(state_r == PWT_DECODE && !hit && local_txn_frame_n) |=> (!devseln_oe && local_txn_frame_n))
		else $error("miss claimed the transaction");
	AST_CLAIM: assert property (@(posedge clk) disable iff (rst) // R4
		(state_r == PWT_DECODE && hit) |=> ##1 (!devseln_o && (ack64n_o == !w64_r)))
		else $error("devsel not asserted one cycle after drivers");
	AST_LOCAL: assert property (@(posedge clk) disable iff (rst) // R7
		(state_r == PWT_DECODE && hit) |=> (!local_txn_frame_n &&
		target_status_vector[NUM_BAR-1:0] == $past(bar_hit) && local_adr == $past(adr_r)))
		else $error("local frame or status bit wrong");
	AST_STAT: assert property (@(posedge clk) disable iff (rst) // R9
		(state_r == PWT_DECODE && hit) |=> (target_status_vector[TSR_BIT_W64] == (WIDE && $past(w64_r))
		&& target_status_vector[TSR_BIT_BUSY]))
		else $error("width or busy status wrong");
	AST_HOLD: assert property (@(posedge clk) disable iff (rst) // R11
		(state_r == PWT_WAIT && local_ready_n) |=> trdyn_o)
		else $error("trdy asserted without local ready");
	AST_TRDY: assert property (@(posedge clk) disable iff (rst) // R13
		(state_r == PWT_WAIT && !local_ready_n && fifo_in_ready) |=> !trdyn_o)
		else $error("trdy late after local ready");
	AST_DATA: assert property (@(posedge clk) disable iff (rst) // R16
		(data_done && !fifo_out_valid) |=> (!local_data_valid_n && local_wdata == $past(wd)
		&& target_status_vector[TSR_BIT_XOK]))
		else $error("data not presented after data phase");
	AST_STROBE: assert property (@(posedge clk) disable iff (rst) // R17
		!local_xfer_strobe_n |-> (!local_data_valid_n && !$past(local_ready_n)))
		else $error("strobe without ready and valid");
	AST_END: assert property (@(posedge clk) disable iff (rst) // R18
		(state_r == PWT_END) |-> (devseln_o && trdyn_o && stopn_o && devseln_oe)
		##1 (!devseln_oe && !ack64n_oe && target_status_vector == TSR_RST))
		else $error("turn-off sequence wrong");
	AST_WIDTH: assert property (@(posedge clk) disable iff (rst) // R14
		ack64n_oe |-> (WIDE && w64_r))
		else $error("ack64 driven outside a 64-bit transfer");
endmodule // pwt_target

// File: sim/pwt_master.sv
// PCI master and local-side user logic model facing the target write path
`timescale 1ns/1ps

module pwt_master (
	input  wire logic        clk,                 // PCI clock
	input  wire logic        rst,                 // Async reset
	output logic             framen,              // Bus frame
	output logic             req64n,              // 64-bit request
	output logic             irdyn,               // Initiator ready
	output logic      [63:0] ad,                  // Address/data
	output logic      [7:0]  cben,                // Command/byte enables
	input  wire logic        devseln_o,           // Device select
	input  wire logic        devseln_oe,          // Devsel driven
	input  wire logic        trdyn_o,             // Target ready
	input  wire logic        trdyn_oe,            // Trdy driven
	input  wire logic        ack64n_o,            // 64-bit ack
	output logic             local_ready_n,       // Local side ready
	input  wire logic        local_data_valid_n,  // Data valid
	input  wire logic        local_xfer_strobe_n, // Local transfer
	input  wire logic [63:0] local_wdata,         // Write data
	input  wire logic [7:0]  local_be_n,          // Byte enables
	input  wire logic [11:0] target_status_vector // Status
);
	int          rdy_wait = 1;    // Claim cycles before local ready
	logic        stall    = 1'b0; // Local side gives one ready pulse only
	int          cnt;             // Cycles with devsel driven
	logic [83:0] got[$];          // Status, enables, data per local transfer

	// Control lines idle high, address/data and enables idle at 0; released lines carry the inverse of the last value
	initial begin
		framen = 1'b1;
		req64n = 1'b1;
		irdyn  = 1'b1;
		ad     = 64'h0;
		cben   = 8'h0;
	end

	// Local side: ready after rdy_wait claim cycles, drains when idle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt           <= 0;
			local_ready_n <= 1'b1;
		end else begin
			cnt <= devseln_oe ? cnt + 1 : 0;
			if (devseln_oe)
				local_ready_n <= !(cnt + 1 >= rdy_wait && (!stall || cnt + 1 == rdy_wait));
			else
				local_ready_n <= stall | local_data_valid_n;
			if (!local_xfer_strobe_n)
				got.push_back({target_status_vector, local_be_n, local_wdata});
		end
	end

	// Single-phase memory write; n is the edge data was taken, 0 on master abort
	task automatic write(input logic [31:0] a, input logic [3:0] c, input logic w64,
		input logic [63:0] d, input logic [7:0] be, input int lim,
		output int n, output int nd, output logic a64);
		n   = 0;
		nd  = 0;
		a64 = 1'b0;
		@(posedge clk);
		framen <= 1'b0;
		req64n <= !w64;
		ad     <= {~a, a};
		cben   <= {~c, c};
		@(posedge clk);
		framen <= 1'b1;
		req64n <= 1'b1;
		irdyn  <= 1'b0;
		ad     <= w64 ? d : {~d[31:0], d[31:0]};
		cben   <= w64 ? be : {~be[3:0], be[3:0]};
		for (int i = 1; i <= lim && n == 0; i++) begin
			@(posedge clk);
			// Unknown pins count as a claim, so they cannot slip through as a miss
			if (nd == 0 && devseln_oe !== 1'b0 && devseln_o !== 1'b1)
				nd = i;
			if (devseln_oe !== 1'b0 && ack64n_o !== 1'b1)
				a64 = 1'b1;
			if (trdyn_oe !== 1'b0 && trdyn_o !== 1'b1)
				n = i;
		end
		irdyn <= 1'b1;
		ad    <= ~ad;
		cben  <= ~cben;
	endtask
endmodule // pwt_master

// File: sim/test_pci_target_write_path.sv
// Self-checking bench for the target write path
`timescale 1ns/1ps

module test_pci_target_write_path import pwt_pkg::*;;
	logic                  clk = 1'b0, rst = 1'b1;
	logic                  framen, req64n, irdyn, local_ready_n;
	logic [63:0]           ad_i, local_wdata;
	logic [7:0]            cben_i, local_be_n;
	logic [NUM_BAR*32-1:0] bar_base, bar_mask;
	logic [NUM_BAR-1:0]    bar_en = 6'h3F;
	logic                  devseln_o, devseln_oe, trdyn_o, trdyn_oe, stopn_o, stopn_oe;
	logic                  ack64n_o, ack64n_oe, local_txn_frame_n;
	logic                  local_data_valid_n, local_xfer_strobe_n;
	logic [TSR_W-1:0]      target_status_vector;
	logic [3:0]            local_cmd;
	logic [31:0]           local_adr;
	int                    miscompares = 0, total_checks = 0;

	pwt_target #(.WIDE(1'b1)) i_pwt_target (.clk, .rst, .framen, .req64n, .irdyn, .ad_i, .cben_i,
		.bar_base, .bar_mask, .bar_en, .devseln_o, .devseln_oe, .trdyn_o, .trdyn_oe, .stopn_o,
		.stopn_oe, .ack64n_o, .ack64n_oe, .local_ready_n, .local_txn_frame_n,
		.target_status_vector, .local_cmd, .local_adr, .local_wdata, .local_be_n,
		.local_data_valid_n, .local_xfer_strobe_n);

	pwt_master i_pwt_master (.clk, .rst, .framen, .req64n, .irdyn, .ad(ad_i), .cben(cben_i),
		.devseln_o, .devseln_oe, .trdyn_o, .trdyn_oe, .ack64n_o, .local_ready_n,
		.local_data_valid_n, .local_xfer_strobe_n, .local_wdata, .local_be_n,
		.target_status_vector);

	// 200 MHz clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [83:0] seen, input logic [83:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One write to window b; claim, hand-off, tear-down all checked
	task automatic wr(input int b, input logic [11:0] off, input logic w64, input logic [63:0] d,
		input logic [7:0] be, input logic [3:0] c, input logic hit);
		logic [31:0] a;
		logic [7:0]  ben;
		logic [11:0] st;
		int          n, nd;
		logic        a64;
		a   = {4'(b + 1), 16'h0000, off};
		st  = hit ? (12'h100 | (12'h001 << b) | {4'h0, w64, 7'h00}) : 12'h000;
		ben = w64 ? be : (a[2] ? {be[3:0], 4'hF} : {4'hF, be[3:0]});
		i_pwt_master.write(a, c, w64, d, be, hit ? 24 : 8, n, nd, a64);
		check("trdy", n, hit ? 3 + i_pwt_master.rdy_wait : 0);
		check("devsel", nd, hit ? 3 : 0);
		check("ack64", a64, hit && w64);
		check("ack64oe", ack64n_oe, hit && w64);
		check("status", target_status_vector, st);
		if (hit)
			check("cmd_adr", {local_cmd, local_adr}, {c, a});
		@(posedge clk);
		if (hit)
			check("end", {devseln_o, trdyn_o, stopn_o, ack64n_o, devseln_oe}, 5'h1F);
		check("local", {local_data_valid_n, local_xfer_strobe_n},
			{!hit, !(hit && !i_pwt_master.stall)});
		@(posedge clk);
		check("release", {target_status_vector, devseln_oe, trdyn_oe, stopn_oe, ack64n_oe},
			16'h0);
		@(posedge clk);
		check("frame", local_txn_frame_n, !(hit && i_pwt_master.stall));
		if (hit && !i_pwt_master.stall)
			check("word", i_pwt_master.got.pop_front(),
				{st | 12'h400, ben, w64 ? d : {2{d[31:0]}}});
		check("pops", i_pwt_master.got.size(), 0);
	endtask

	// Windows at 0x1000_0000 steps, 4 KB each
	initial begin
		for (int i = 0; i < NUM_BAR; i++) begin
			bar_base[i*32+:32] = {4'(i + 1), 28'h0000000};
			bar_mask[i*32+:32] = 32'hFFFF_F000;
		end
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		wr(0, 12'h010, 1'b1, 64'h0123_4567_89AB_CDEF, 8'h0F, CMD_MEM_WR, 1'b1);
		// Every window, alternating dword halves, back to back
		for (int b = 0; b < NUM_BAR; b++)
			wr(b, {9'h000, b[0], 2'h0}, 1'b0, {32'h0, 32'hA5A5_0000 + 32'(b)}, 8'(b + 3),
				CMD_MEM_WR, 1'b1);
		i_pwt_master.rdy_wait = 4;
		wr(2, 12'h3F8, 1'b1, 64'hFEDC_BA98_7654_3210, 8'hA5, CMD_MEM_WR, 1'b1);
		i_pwt_master.rdy_wait = 1;
		wr(7, 12'h000, 1'b1, 64'h1, 8'h00, CMD_MEM_WR, 1'b0);
		wr(0, 12'h000, 1'b0, 64'h2, 8'h00, 4'h6, 1'b0);
		@(posedge clk);
		bar_en <= 6'h1F;
		wr(5, 12'h000, 1'b0, 64'h3, 8'h00, CMD_MEM_WR, 1'b0);
		bar_en <= 6'h3F;
		// Local side holds the word back, frame must stay low
		i_pwt_master.stall <= 1'b1;
		wr(1, 12'h020, 1'b1, 64'h1111_2222_3333_4444, 8'h3C, CMD_MEM_WR, 1'b1);
		// Local ready after one edge, pop on the third, frame up after the fourth
		i_pwt_master.stall <= 1'b0;
		repeat (5) @(posedge clk);
		check("held", i_pwt_master.got.pop_front(),
			{12'h000, 8'h3C, 64'h1111_2222_3333_4444});
		check("frame", local_txn_frame_n, 1'b1);
		results();
	end

	// Hang guard, far beyond the roughly 140 cycles of the tests
	initial begin
		#25000;
		miscompares++;
		results();
	end
endmodule // test_pci_target_write_path
